// >>> rtl/lfb_pkg.sv
/*
  lfb_pkg: constants and types shared by the flash bus front end.
  Assumes a single 200 MHz core clock (mclk) and a synchronous reset.
*/
package lfb_pkg;

  // start nibbles recognised on the nibble bus
  localparam logic [3:0] LFB_START_LPC   = 4'h0;
  localparam logic [3:0] LFB_START_HUB_RD = 4'hd;
  localparam logic [3:0] LFB_START_HUB_WR = 4'he;

  // cycle-type nibble: bits 3:2 give the kind, bit 1 the direction
  localparam int         LFB_CT_KIND_MSB = 3;
  localparam int         LFB_CT_KIND_LSB = 2;
  localparam int         LFB_CT_DIR_BIT  = 1;
  localparam logic [1:0] LFB_KIND_MEM    = 2'h1;

  // turnaround nibble driven before release
  localparam logic [3:0] LFB_TAR_NIBBLE  = 4'hf;

  // status bit mirrored on the ready/busy output
  localparam int         LFB_STAT_READY_BIT = 7;
  localparam logic [7:0] LFB_STATUS_RST     = 8'h80;

  // address split of the multiplexed programming port
  localparam int LFB_ROW_W = 11;
  localparam int LFB_COL_W = 7;
  localparam int LFB_ADR_W = 18;

  // reset values
  localparam logic       LFB_MODE_RST = 1'b0;
  localparam logic [7:0] LFB_BYTE_RST = 8'h00;

  // decoded cycle classes
  typedef enum logic [2:0]
  {
    LFB_CYC_NONE,
    LFB_CYC_LPC_MEM_RD,
    LFB_CYC_LPC_MEM_WR,
    LFB_CYC_HUB_RD,
    LFB_CYC_HUB_WR
  } lfb_cyc_t;

endpackage : lfb_pkg

// >>> rtl/lfb_sync.sv
/*
  lfb_sync: two-flop synchroniser for a vector of pin inputs.
  Assumes the inputs are asynchronous to mclk; reset is synchronous.
*/
`timescale 1ns/100ps
`default_nettype none

module lfb_sync #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         mclk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] meta_q;

  // first stage feeds only the second stage; reset loads the pins' idle
  // levels so no false edge or frame is seen as reset ends
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      meta_q <= RST_VAL;
      dout   <= RST_VAL;
    end
    else
    begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end

endmodule : lfb_sync

`default_nettype wire

// >>> rtl/lfb_front_end.sv
/*
  lfb_front_end: interface selection, start-nibble decode and the
  multiplexed programming port of a BIOS flash front end.
  Assumes all pins are asynchronous to mclk and pass a two-flop
  synchroniser; the array, protection and registers sit elsewhere.
*/
// Operation
// - strap low selects nibble bus interface, high selects programming port
// - row address latched on strobe fall, column address on strobe rise
// - programming writes latch data; reads drive array, status or identifier data
// - programming data pins float while output enable is high
// - ready/busy output mirrors status bit 7 in programming mode
// - start 0000b is standard cycle; answer only memory kinds of next nibble
// - start 1101b decodes hub read, 1110b hub write
// - unknown start floats nibble bus; standby once frame high and idle
// - frame sampled low stops nibble drive next clock, watch for new cycle
// - nibble bus pins sampled on mclk through the two-flop synchroniser
`timescale 1ns/100ps
`default_nettype none

module lfb_front_end
  import lfb_pkg::*;
(
  input  wire logic                 mclk,
  input  wire logic                 rst_n,
  input  wire logic                 interface_select_pin,
  input  wire logic                 frame_strobe_n,
  input  wire logic [3:0]           nibble_bus_i,
  output logic      [3:0]           nibble_bus_o,
  output logic                      nibble_bus_oe,
  input  wire logic [LFB_ROW_W-1:0] mux_address_pins,
  input  wire logic                 row_column_strobe,
  input  wire logic                 output_enable_n,
  input  wire logic                 write_enable_n,
  input  wire logic [7:0]           mux_data_pins_i,
  output logic      [7:0]           mux_data_pins_o,
  output logic                      mux_data_pins_oe,
  output logic                      ready_busy_out,
  input  wire logic [7:0]           read_data,
  input  wire logic                 op_busy,
  output logic                      mux_mode,
  output logic      [LFB_ADR_W-1:0] mux_address,
  output logic      [7:0]           write_data,
  output logic                      write_strobe,
  output logic      [2:0]           cycle_class,
  output logic                      cycle_valid,
  output logic                      standby
);

  typedef enum logic [1:0]
  {
    LFB_ST_IDLE,
    LFB_ST_TYPE,
    LFB_ST_ACTIVE,
    LFB_ST_IGNORE
  } lfb_state_t;

  // synchronised pin copies
  logic [LFB_ROW_W-1:0] adr_s;
  logic [7:0]           dat_s;
  logic                 ic_s;
  logic                 frame_n_s;
  logic [3:0]           lad_s;
  logic                 rc_s;
  logic                 oe_n_s;
  logic                 we_n_s;

  logic                 rc_q;
  logic                 we_n_q;
  logic                 mode_q;
  logic                 mode_known_q;
  lfb_state_t           state_q;
  logic [7:0]           status_q;
  logic                 nib_oe_q;

  // idle levels: frame, strobe and both enables high, all else low
  lfb_sync #(
    .W       (LFB_ROW_W + 17),
    .RST_VAL ({{(LFB_ROW_W + 9){1'b0}}, 1'b1, 4'h0, 3'h7})
  ) u_sync (
    .mclk  (mclk),
    .rst_n (rst_n),
    .din   ({mux_address_pins, mux_data_pins_i, interface_select_pin,
             frame_strobe_n, nibble_bus_i, row_column_strobe,
             output_enable_n, write_enable_n}),
    .dout  ({adr_s, dat_s, ic_s, frame_n_s, lad_s, rc_s, oe_n_s, we_n_s})
  );

  // a memory-kind check used for both directions of the standard cycle
  function automatic logic is_mem_kind(input logic [3:0] ct);
    is_mem_kind = (ct[LFB_CT_KIND_MSB:LFB_CT_KIND_LSB] == LFB_KIND_MEM);
  endfunction : is_mem_kind

  // strap is re-sampled only when nothing is in flight, so a glitch on it
  // cannot flip the interface in the middle of a transfer
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      mode_q       <= LFB_MODE_RST;
      mode_known_q <= 1'b0;
    end
    else if (!mode_known_q || ((state_q == LFB_ST_IDLE || state_q == LFB_ST_IGNORE)
                               && !op_busy && frame_n_s && we_n_s && rc_s))
    begin
      mode_q       <= ic_s;
      mode_known_q <= 1'b1;
    end
  end

  assign mux_mode = mode_q;

  // start-nibble decode; the last nibble seen with frame low is the start
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      state_q     <= LFB_ST_IDLE;
      cycle_class <= LFB_CYC_NONE;
      cycle_valid <= 1'b0;
    end
    else
    begin
      cycle_valid <= 1'b0;
      if (mode_q)
      begin
        state_q     <= LFB_ST_IDLE;
        cycle_class <= LFB_CYC_NONE;
      end
      else if (!frame_n_s)
      begin
        // frame low always restarts decode, which also covers aborts
        cycle_class <= LFB_CYC_NONE;
        unique case (lad_s)
          LFB_START_LPC:    state_q <= LFB_ST_TYPE;
          LFB_START_HUB_RD: cycle_class <= LFB_CYC_HUB_RD;
          LFB_START_HUB_WR: cycle_class <= LFB_CYC_HUB_WR;
          default:          state_q <= LFB_ST_IGNORE;
        endcase
        if (lad_s == LFB_START_HUB_RD || lad_s == LFB_START_HUB_WR)
          state_q <= LFB_ST_ACTIVE;
      end
      else
      begin
        unique case (state_q)
          LFB_ST_IDLE:   state_q <= LFB_ST_IDLE;
          LFB_ST_TYPE:
          begin
            if (is_mem_kind(lad_s))
            begin
              cycle_class <= lad_s[LFB_CT_DIR_BIT] ? LFB_CYC_LPC_MEM_WR
                                                   : LFB_CYC_LPC_MEM_RD;
              cycle_valid <= 1'b1;
              state_q     <= LFB_ST_ACTIVE;
            end
            else
              state_q <= LFB_ST_IGNORE;
          end
          LFB_ST_ACTIVE:
          begin
            // hub class reported on the first clock after frame rises
            if (cycle_class == LFB_CYC_HUB_RD || cycle_class == LFB_CYC_HUB_WR)
              cycle_valid <= 1'b1;
            state_q <= LFB_ST_IDLE;
          end
          LFB_ST_IGNORE: state_q <= LFB_ST_IGNORE;
        endcase
      end
    end
  end

  // the field engine is outside; this block only owns the release rule
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      nib_oe_q <= 1'b0;
    else
      nib_oe_q <= 1'b0;
  end

  assign nibble_bus_o  = LFB_TAR_NIBBLE;
  assign nibble_bus_oe = nib_oe_q;

  // standby in nibble bus mode when frame high, no operation running, no decode in flight
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      standby <= 1'b0;
    else
      standby <= !mode_q && frame_n_s && !op_busy
                 && (state_q == LFB_ST_IGNORE || state_q == LFB_ST_IDLE);
  end

  // row on the strobe's fall, column on its rise
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      rc_q        <= 1'b1;
      mux_address <= '0;
    end
    else
    begin
      rc_q <= rc_s;
      if (mode_q && rc_q && !rc_s)
        mux_address[LFB_ROW_W-1:0] <= adr_s;
      if (mode_q && !rc_q && rc_s)
        mux_address[LFB_ADR_W-1:LFB_ROW_W] <= adr_s[LFB_COL_W-1:0];
    end
  end

  // data latched as write enable rises, the usual trailing-edge capture
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      we_n_q       <= 1'b1;
      write_data   <= LFB_BYTE_RST;
      write_strobe <= 1'b0;
    end
    else
    begin
      we_n_q       <= we_n_s;
      write_strobe <= 1'b0;
      if (mode_q && !we_n_q && we_n_s)
      begin
        write_data   <= dat_s;
        write_strobe <= 1'b1;
      end
    end
  end

  // status copy; ready bit falls while an operation runs
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      status_q <= LFB_STATUS_RST;
    else
    begin
      status_q <= read_data;
      status_q[LFB_STAT_READY_BIT] <= !op_busy;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      ready_busy_out <= 1'b1;
    else
      ready_busy_out <= mode_q ? status_q[LFB_STAT_READY_BIT] : 1'b1;
  end

  // read drive only with output enable low and write enable high
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      mux_data_pins_o  <= LFB_BYTE_RST;
      mux_data_pins_oe <= 1'b0;
    end
    else
    begin
      mux_data_pins_o  <= read_data;
      mux_data_pins_oe <= mode_q && !oe_n_s && we_n_s;
    end
  end

  // output enable high must float the data pins by the next clock
  AST_DATA_FLOAT: assert property (@(posedge mclk) disable iff (!rst_n)
    oe_n_s |=> !mux_data_pins_oe)
    else $error("data pins driven with output enable high");

  // drive never in lpc mode
  AST_DATA_MODE: assert property (@(posedge mclk) disable iff (!rst_n)
    mux_data_pins_oe |-> $past(mode_q))
    else $error("data pins driven outside programming mode");

  // row fall captures address low bits
  AST_ROW_LATCH: assert property (@(posedge mclk) disable iff (!rst_n)
    (mode_q && rc_q && !rc_s) |=> mux_address[LFB_ROW_W-1:0] == $past(adr_s))
    else $error("row address not captured");

  // column rise captures high bits
  AST_COL_LATCH: assert property (@(posedge mclk) disable iff (!rst_n)
    (mode_q && !rc_q && rc_s)
    |=> mux_address[LFB_ADR_W-1:LFB_ROW_W] == $past(adr_s[LFB_COL_W-1:0]))
    else $error("column address not captured");

  // nibble bus released the clock after frame low
  AST_FRAME_RELEASE: assert property (@(posedge mclk) disable iff (!rst_n)
    !frame_n_s |=> !nibble_bus_oe)
    else $error("nibble bus still driven after frame");

  // ready mirrors busy with two-cycle latency
  sequence s_busy_seen;
    mode_q && op_busy;
  endsequence
  AST_READY_BUSY: assert property (@(posedge mclk) disable iff (!rst_n)
    s_busy_seen ##1 mode_q |=> !ready_busy_out)
    else $error("ready output high while busy");

  // hub read start decodes to hub read class
  AST_HUB_READ: assert property (@(posedge mclk) disable iff (!rst_n)
    (!mode_q && !frame_n_s && lad_s == LFB_START_HUB_RD)
    |=> cycle_class == LFB_CYC_HUB_RD)
    else $error("hub read start not decoded");

  AST_HUB_WRITE: assert property (@(posedge mclk) disable iff (!rst_n)
    (!mode_q && !frame_n_s && lad_s == LFB_START_HUB_WR)
    |=> cycle_class == LFB_CYC_HUB_WR)
    else $error("hub write start not decoded");

  // non memory kind after standard start never becomes valid
  AST_LPC_NONMEM: assert property (@(posedge mclk) disable iff (!rst_n)
    (state_q == LFB_ST_TYPE && frame_n_s && !is_mem_kind(lad_s)) |=> !cycle_valid)
    else $error("non memory cycle accepted");

  // strap held while a write is in progress
  AST_STRAP_HOLD: assert property (@(posedge mclk) disable iff (!rst_n)
    (mode_known_q && !we_n_s) |=> $stable(mode_q))
    else $error("mode changed during a write");

  // unknown start leaves bus floated and reaches standby
  AST_STANDBY: assert property (@(posedge mclk) disable iff (!rst_n)
    (!mode_q && state_q == LFB_ST_IGNORE && frame_n_s && !op_busy)
    |=> standby && !nibble_bus_oe)
    else $error("standby not entered after unknown start");

endmodule : lfb_front_end

`default_nettype wire

// >>> dv/lfb_host_model.sv
/*
  lfb_host_model: nibble bus host that frames cycles for the front end.
  Assumes it shares mclk with the device and changes pins 1 ns after an edge.
*/
`timescale 1ns/100ps
`default_nettype none

module lfb_host_model (
  input  wire logic       mclk,
  input  wire logic [3:0] dev_o,
  input  wire logic       dev_oe,
  output logic            frame_strobe_n,
  output logic      [3:0] nibble_bus
);
  logic       drv;
  logic [3:0] val;

  // a released bus floats up to the pull-up level
  assign nibble_bus = dev_oe ? dev_o : (drv ? val : 4'hf);

  initial
  begin
    frame_strobe_n = 1'b1;
    drv = 1'b0;
    val = 4'h0;
  end

  // frame low two clocks with the start nibble, then the type nibble
  task automatic frame_cycle(input logic [3:0] start, input logic [3:0] ctype);
  begin
    @(posedge mclk);
    #1;
    frame_strobe_n = 1'b0;
    drv = 1'b1;
    val = start;
    repeat (2) @(posedge mclk);
    #1;
    frame_strobe_n = 1'b1;
    val = ctype;
    @(posedge mclk);
    #1;
    drv = 1'b0;
  end
  endtask : frame_cycle
endmodule : lfb_host_model
`default_nettype wire

// >>> dv/lfb_front_end_tb_top.sv
/*
  lfb_front_end_tb_top: self-checking bench for the flash bus front end.
  Assumes the host model in lfb_host_model and a 200 MHz mclk.
*/
`timescale 1ns/100ps
`default_nettype none

module lfb_front_end_tb_top;
  import lfb_pkg::*;
  logic mclk = 1'b0, rst_n = 1'b0, strap = 1'b0, fr_n, rc = 1'b1;
  logic oe_n = 1'b1, we_n = 1'b1, op_busy = 1'b0, pd_en = 1'b0;
  logic [3:0] nb, nb_o;
  logic [10:0] map = 11'h000;
  logic [7:0] pd = 8'h00, md_i, md_o, write_data, read_data = 8'h00;
  logic [LFB_ADR_W-1:0] mux_address;
  logic [2:0] cycle_class;
  logic nb_oe, md_oe, ready_busy_out, mux_mode, write_strobe, cycle_valid, standby;
  int n_errors = 0, cmp_count = 0;

  // released data lines show the inverse of the last value
  assign md_i = md_oe ? md_o : (pd_en ? pd : ~pd);
  always #2.5 mclk = ~mclk;

  lfb_host_model host (.mclk(mclk), .dev_o(nb_o), .dev_oe(nb_oe),
    .frame_strobe_n(fr_n), .nibble_bus(nb));

  lfb_front_end DUT (.mclk(mclk), .rst_n(rst_n), .interface_select_pin(strap),
    .frame_strobe_n(fr_n), .nibble_bus_i(nb), .nibble_bus_o(nb_o), .nibble_bus_oe(nb_oe),
    .mux_address_pins(map), .row_column_strobe(rc), .output_enable_n(oe_n),
    .write_enable_n(we_n), .mux_data_pins_i(md_i), .mux_data_pins_o(md_o),
    .mux_data_pins_oe(md_oe), .ready_busy_out(ready_busy_out), .read_data(read_data),
    .op_busy(op_busy), .mux_mode(mux_mode), .mux_address(mux_address),
    .write_data(write_data), .write_strobe(write_strobe), .cycle_class(cycle_class),
    .cycle_valid(cycle_valid), .standby(standby));

  task automatic summarize;
  begin
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  end
  endtask : summarize

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
  begin
    cmp_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  end
  endtask : check

  task automatic step(input int n);
  begin
    repeat (n) @(posedge mclk);
    #1;
  end
  endtask : step

  // count pulses of cycle_valid (sel 0) or write_strobe (sel 1)
  task automatic pulses(input int sel, input int lim, output int seen);
  begin
    seen = 0;
    repeat (lim)
    begin
      step(1);
      if ((sel == 0 ? cycle_valid : write_strobe) === 1'b1)
        seen++;
    end
  end
  endtask : pulses

  // every recognised start and both memory directions
  task automatic t_decode;
    logic [3:0] st[4] = '{4'hd, 4'he, 4'h0, 4'h0};
    logic [3:0] ct[4] = '{4'h0, 4'h0, 4'h4, 4'h6};
    logic [2:0] ex[4] = '{3'h3, 3'h4, 3'h1, 3'h2};
    int i, k;
  begin
    for (i = 0; i < 4; i++)
    begin
      fork
        host.frame_cycle(st[i], ct[i]);
        begin
          pulses(0, 12, k);
        end
      join
      check(k, 1);
      check(cycle_class, ex[i]);
    end
  end
  endtask : t_decode

  // unknown start and a non-memory kind are left alone
  task automatic t_ignore;
    int k;
  begin
    host.frame_cycle(4'h5, 4'h4);
    pulses(0, 10, k);
    check(k, 0);
    check(standby, 1'b1);
    check(nb_oe, 1'b0);
    host.frame_cycle(4'h0, 4'h0);
    pulses(0, 10, k);
    check(k, 0);
  end
  endtask : t_ignore

  // programming port: address, write, read, ready and strap
  task automatic t_prog;
    int k;
  begin
    strap = 1'b1;
    step(8);
    check(mux_mode, 1'b1);
    map = 11'h5a3;
    rc = 1'b0;
    step(5);
    map = 11'h02b;
    rc = 1'b1;
    step(5);
    check(mux_address, {7'h2b, 11'h5a3});
    pd = 8'h3c;
    pd_en = 1'b1;
    we_n = 1'b0;
    step(4);
    we_n = 1'b1;
    pulses(1, 6, k);
    check(k, 1);
    check(write_data, 8'h3c);
    pd_en = 1'b0;
    check(md_oe, 1'b0);
    read_data = 8'ha5;
    oe_n = 1'b0;
    step(5);
    check({md_oe, md_o}, {1'b1, 8'ha5});
    oe_n = 1'b1;
    step(5);
    check(md_oe, 1'b0);
    op_busy = 1'b1;
    strap = 1'b0;
    step(6);
    check(ready_busy_out, 1'b0);
    check(mux_mode, 1'b1);
    op_busy = 1'b0;
    step(8);
    check({mux_mode, ready_busy_out}, 2'b01);
  end
  endtask : t_prog

  initial
  begin
    step(6);
    rst_n = 1'b1;
    step(4);
    check({nb_oe, md_oe, mux_mode, ready_busy_out}, 4'h1);
    t_decode();
    t_ignore();
    t_prog();
    t_decode();
    summarize();
  end

  // hang guard at 20000 clocks, far above the length of the run
  initial
  begin
    #100000;
    n_errors++;
    summarize();
  end
endmodule : lfb_front_end_tb_top
`default_nettype wire
